// >>> slrt_timer_cfg.sv
// Slope ramp timer with its 6-phase and 5-phase setting registers
`timescale 1ns/1ps
`default_nettype none

module slrt_timer_cfg
	import slrt_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Management register port
	input wire logic reg_wr_en_in,
	input wire logic reg_rd_en_in,
	input wire logic [7:0] reg_cmd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rd_valid_out,
	output logic reg_cmd_known_out,
	// Phase status and ramp trigger
	input wire logic [3:0] active_phases_in,
	input wire logic ramp_start_in,
	// Analog ramp controls
	output logic slope_src_en_out,
	output logic ramp_hold_out,
	output logic [2:0] ramp_cap_select_out,
	output logic [5:0] ramp_current_code_out,
	output logic slew_five_active_out,
	output logic [8:0] ramp_elapsed_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// True for any of the three command codes this block owns
	function automatic logic cmd_mapped(input logic [7:0] cmd);
		cmd_mapped = (cmd == SLRT_CMD_LIMIT_SIX) || (cmd == SLRT_CMD_SLEW_FIVE) ||
			(cmd == SLRT_CMD_LIMIT_FIVE);
	endfunction

	// Register image with unused upper bits forced to zero
	function automatic logic [15:0] reg_image(input logic [7:0] cmd, input logic [7:0] lim6,
		input logic [8:0] slew5, input logic [7:0] lim5);
		case (cmd)
			SLRT_CMD_LIMIT_SIX: reg_image = {8'h00, lim6} & SLRT_LIMIT_MASK;
			SLRT_CMD_SLEW_FIVE: reg_image = {7'h00, slew5} & SLRT_SLEW_MASK;
			SLRT_CMD_LIMIT_FIVE: reg_image = {8'h00, lim5} & SLRT_LIMIT_MASK;
			default: reg_image = 16'h0000;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Setting registers
	// ----------------------------------------------------------------
	logic [7:0] limit_six_reg;
	logic [7:0] limit_six_next;
	logic [8:0] slew_five_reg;
	logic [8:0] slew_five_next;
	logic [7:0] limit_five_reg;
	logic [7:0] limit_five_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rd_valid_reg;
	logic rd_valid_next;
	logic known_reg;
	logic known_next;

	// Write decode; reads answer one cycle after the strobe
	always_comb begin
		limit_six_next = limit_six_reg;
		slew_five_next = slew_five_reg;
		limit_five_next = limit_five_reg;
		rdata_next = rdata_reg;
		rd_valid_next = reg_rd_en_in;
		known_next = known_reg;
		if (reg_wr_en_in) begin
			case (reg_cmd_in)
				SLRT_CMD_LIMIT_SIX: limit_six_next = reg_wdata_in[SLRT_LIMIT_MSB:SLRT_LIMIT_LSB];
				SLRT_CMD_SLEW_FIVE: slew_five_next = reg_wdata_in[SLRT_CAP_MSB:SLRT_CUR_LSB];
				SLRT_CMD_LIMIT_FIVE: limit_five_next = reg_wdata_in[SLRT_LIMIT_MSB:SLRT_LIMIT_LSB];
				default: limit_six_next = limit_six_reg;
			endcase
		end
		if (reg_rd_en_in) begin
			rdata_next = reg_image(reg_cmd_in, limit_six_reg, slew_five_reg, limit_five_reg);
		end
		// Unknown codes are flagged so the protocol engine can refuse them
		if (reg_rd_en_in || reg_wr_en_in) begin
			known_next = cmd_mapped(reg_cmd_in);
		end
	end

	// Setting register flops
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			limit_six_reg <= SLRT_LIMIT_RST;
			slew_five_reg <= SLRT_SLEW_RST;
			limit_five_reg <= SLRT_LIMIT_RST;
			rdata_reg <= 16'h0000;
			rd_valid_reg <= 1'b0;
			known_reg <= 1'b0;
		end else begin
			limit_six_reg <= limit_six_next;
			slew_five_reg <= slew_five_next;
			limit_five_reg <= limit_five_next;
			rdata_reg <= rdata_next;
			rd_valid_reg <= rd_valid_next;
			known_reg <= known_next;
		end
	end

	// ----------------------------------------------------------------
	// Ramp timer
	// ----------------------------------------------------------------
	slrt_state_t state_reg;
	slrt_state_t state_next;
	logic [8:0] count_reg;
	logic [8:0] count_next;
	logic [7:0] limit_reg;
	logic [7:0] limit_next;
	logic limited_reg;
	logic limited_next;
	logic src_en_reg;
	logic src_en_next;
	logic [9:0] count_sum;
	logic [7:0] phase_limit;
	logic phase_limited;

	// Pick the limit for the present phase count
	always_comb begin
		phase_limit = SLRT_LIMIT_RST;
		phase_limited = 1'b0;
		case (active_phases_in)
			SLRT_PHASE_SIX: begin
				phase_limit = limit_six_reg;
				phase_limited = 1'b1;
			end
			SLRT_PHASE_FIVE: begin
				phase_limit = limit_five_reg;
				phase_limited = 1'b1;
			end
			default: phase_limited = 1'b0;
		endcase
	end

	// Two 5 ns steps per clock; limit latched at start so a write mid-ramp waits
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		limit_next = limit_reg;
		limited_next = limited_reg;
		src_en_next = src_en_reg;
		// count in 5 ns units, one bit wider so full scale cannot wrap to zero
		count_sum = {1'b0, count_reg} + {1'b0, SLRT_STEPS_PER_CLK};
		if (ramp_start_in) begin
			count_next = 9'h000;
			limit_next = phase_limit;
			limited_next = phase_limited;
			if (phase_limited && (phase_limit == 8'h00)) begin
				state_next = SLRT_HOLD;
				src_en_next = 1'b0;
			end else begin
				state_next = SLRT_RAMP;
				src_en_next = 1'b1;
			end
		end else begin
			case (state_reg)
				SLRT_IDLE: src_en_next = 1'b0;
				SLRT_RAMP: begin
					// stop source and hold at limit
					if (limited_reg && (count_sum >= {2'b00, limit_reg})) begin
						state_next = SLRT_HOLD;
						src_en_next = 1'b0;
						count_next = {1'b0, limit_reg};
					end else if (count_sum > 10'h1ff) begin
						// Unlimited ramp: elapsed time pins at full scale
						count_next = 9'h1ff;
					end else begin
						count_next = count_sum[8:0];
					end
				end
				SLRT_HOLD: src_en_next = 1'b0;
				default: begin
					state_next = SLRT_IDLE;
					src_en_next = 1'b0;
				end
			endcase
		end
	end

	// Timer flops
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= SLRT_IDLE;
			count_reg <= 9'h000;
			limit_reg <= SLRT_LIMIT_RST;
			limited_reg <= 1'b0;
			src_en_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			limit_reg <= limit_next;
			limited_reg <= limited_next;
			src_en_reg <= src_en_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Register port answers
	assign reg_rdata_out = rdata_reg;
	assign reg_rd_valid_out = rd_valid_reg;
	assign reg_cmd_known_out = known_reg;

	// Ramp source and hold
	assign slope_src_en_out = src_en_reg;
	assign ramp_hold_out = (state_reg == SLRT_HOLD);
	assign ramp_elapsed_out = count_reg;

	// Slew fields straight from the register flops; five-phase flag decoded from active_phases_in
	// capacitor code field
	assign ramp_cap_select_out = slew_five_reg[SLRT_CAP_MSB:SLRT_CAP_LSB];
	assign ramp_current_code_out = slew_five_reg[SLRT_CUR_MSB:SLRT_CUR_LSB];
	assign slew_five_active_out = (active_phases_in == SLRT_PHASE_FIVE);

endmodule // slrt_timer_cfg

`default_nettype wire

// >>> slrt_pkg.sv
// Constants for the slope ramp timer and its setting registers
package slrt_pkg;

	// ----------------------------------------------------------------
	// Command codes of the setting registers
	// ----------------------------------------------------------------
	localparam logic [7:0] SLRT_CMD_LIMIT_SIX = 8'hd1;
	localparam logic [7:0] SLRT_CMD_SLEW_FIVE = 8'hd2;
	localparam logic [7:0] SLRT_CMD_LIMIT_FIVE = 8'hd3;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int SLRT_LIMIT_MSB = 7;
	localparam int SLRT_LIMIT_LSB = 0;
	localparam int SLRT_CAP_MSB = 8;
	localparam int SLRT_CAP_LSB = 6;
	localparam int SLRT_CUR_MSB = 5;
	localparam int SLRT_CUR_LSB = 0;
	localparam logic [15:0] SLRT_LIMIT_MASK = 16'h00ff;
	localparam logic [15:0] SLRT_SLEW_MASK = 16'h01ff;

	// ----------------------------------------------------------------
	// Reset values and phase-count codes
	// ----------------------------------------------------------------
	localparam logic [7:0] SLRT_LIMIT_RST = 8'h00;
	localparam logic [8:0] SLRT_SLEW_RST = 9'h000;
	localparam logic [3:0] SLRT_PHASE_SIX = 4'h6;
	localparam logic [3:0] SLRT_PHASE_FIVE = 4'h5;

	// ----------------------------------------------------------------
	// Timing: one limit step is 5 ns, the clock period is 10 ns
	// ----------------------------------------------------------------
	localparam int SLRT_STEP_NS = 5;
	localparam int SLRT_CLK_PERIOD_NS = 10;
	localparam logic [8:0] SLRT_STEPS_PER_CLK = 9'(SLRT_CLK_PERIOD_NS / SLRT_STEP_NS);

	// Ramp timer states
	typedef enum logic [2:0] {
		SLRT_IDLE = 3'b001,
		SLRT_RAMP = 3'b010,
		SLRT_HOLD = 3'b100
	} slrt_state_t;

endpackage

// >>> slrt_timer_cfg_asserts.sv
// Port checker for the slope ramp timer and its setting registers
`timescale 1ns/1ps
`default_nettype none
module slrt_timer_cfg_chk
	import slrt_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Register port
	input wire logic reg_rd_en_in,
	input wire logic [7:0] reg_cmd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic reg_rd_valid_out,
	// Ramp side
	input wire logic [3:0] active_phases_in,
	input wire logic ramp_start_in,
	input wire logic slope_src_en_out,
	input wire logic ramp_hold_out,
	input wire logic slew_five_active_out,
	input wire logic [8:0] ramp_elapsed_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_LIM_HI: assert property (reg_rd_en_in && reg_cmd_in[1:0] != 2'h2 && reg_cmd_in[7:4] == 4'hd
		&& reg_cmd_in[3:2] == 2'h0 |=> reg_rdata_out[15:8] == 8'h00) else $error("limit high byte set");
	AST_SLEW_HI: assert property (reg_rd_en_in && reg_cmd_in == SLRT_CMD_SLEW_FIVE
		|=> reg_rdata_out[15:9] == 7'h00) else $error("slew upper bits set");
	AST_RD_VALID: assert property (reg_rd_en_in |=> reg_rd_valid_out) else $error("no read valid");
	AST_RD_PULSE: assert property (!reg_rd_en_in |=> !reg_rd_valid_out) else $error("stray valid");
	AST_EXCL: assert property (!(slope_src_en_out && ramp_hold_out)) else $error("on while held");
	AST_HOLD_STAY: assert property (ramp_hold_out && !ramp_start_in |=> ramp_hold_out)
		else $error("hold dropped");
	AST_HOLD_FROZEN: assert property (ramp_hold_out && !ramp_start_in |=> $stable(ramp_elapsed_out))
		else $error("held time moved");
	AST_START: assert property (ramp_start_in |=> ramp_elapsed_out == 9'h000
		&& (slope_src_en_out ^ ramp_hold_out)) else $error("bad ramp start");
	AST_FIVE: assert property (slew_five_active_out == (active_phases_in == SLRT_PHASE_FIVE))
		else $error("five phase flag wrong");
	// Main scenarios
	cover property (ramp_start_in ##1 slope_src_en_out ##[1:200] ramp_hold_out);
	cover property (ramp_start_in ##1 ramp_hold_out);
	cover property (reg_rd_en_in && reg_cmd_in == SLRT_CMD_SLEW_FIVE);
endmodule // slrt_timer_cfg_chk
bind slrt_timer_cfg slrt_timer_cfg_chk chk_u (
	.sys_clk_in(sys_clk_in),
	.sys_rst_in(sys_rst_in),
	.reg_rd_en_in(reg_rd_en_in),
	.reg_cmd_in(reg_cmd_in),
	.reg_rdata_out(reg_rdata_out),
	.reg_rd_valid_out(reg_rd_valid_out),
	.active_phases_in(active_phases_in),
	.ramp_start_in(ramp_start_in),
	.slope_src_en_out(slope_src_en_out),
	.ramp_hold_out(ramp_hold_out),
	.slew_five_active_out(slew_five_active_out),
	.ramp_elapsed_out(ramp_elapsed_out)
);
`default_nettype wire

// >>> slrt_tb.sv
// Self-checking testbench for the slope ramp timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import slrt_pkg::*;
	logic sys_clk_in = 0, sys_rst_in = 1, wr_en = 0, rd_en = 0, start = 0;
	logic [7:0] cmd = 8'h00;
	logic [15:0] wdata = 16'h0000, rdata;
	logic [3:0] phases = 4'h0;
	logic rd_valid, known, src_en, hold, slew5;
	logic [2:0] cap;
	logic [5:0] cur;
	logic [8:0] elapsed;
	int mismatches = 0, checked = 0;
	// Free-running 100 MHz clock
	always #5 sys_clk_in = ~sys_clk_in;
	slrt_timer_cfg dut_u (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .reg_wr_en_in(wr_en),
		.reg_rd_en_in(rd_en), .reg_cmd_in(cmd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_rd_valid_out(rd_valid), .reg_cmd_known_out(known), .active_phases_in(phases),
		.ramp_start_in(start), .slope_src_en_out(src_en), .ramp_hold_out(hold),
		.ramp_cap_select_out(cap), .ramp_current_code_out(cur),
		.slew_five_active_out(slew5), .ramp_elapsed_out(elapsed));
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] c, input logic [15:0] d);
		@(posedge sys_clk_in);
		wr_en <= 1'b1;
		cmd <= c;
		wdata <= d;
		@(posedge sys_clk_in);
		wr_en <= 1'b0;
	endtask
	// Read is answered one cycle after the strobe edge
	task automatic rd_reg(input logic [7:0] c, input logic [15:0] e, input logic k);
		@(posedge sys_clk_in);
		rd_en <= 1'b1;
		cmd <= c;
		@(posedge sys_clk_in);
		rd_en <= 1'b0;
		#1;
		chk({15'h0, rd_valid}, 16'h0001);
		chk(rdata, e);
		chk({15'h0, known}, {15'h0, k});
	endtask
	// One ramp: source on for ceil(limit/2) cycles, then held at the limit
	task automatic ramp(input logic [3:0] ph, input int lim);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		phases <= ph;
		start <= 1'b1;
		@(posedge sys_clk_in);
		start <= 1'b0;
		#1;
		while (src_en === 1'b1 && n < 300) begin
			n++;
			@(posedge sys_clk_in);
			#1;
		end
		if (n == 300) begin
			mismatches++;
			print_verdict();
		end
		chk(16'(n), 16'((lim + 1) / 2));
		chk({15'h0, hold}, 16'h0001);
		chk({7'h0, elapsed}, 16'(lim));
	endtask
	task automatic scn_regs();
		rd_reg(SLRT_CMD_LIMIT_SIX, 16'h0000, 1'b1);
		wr_reg(SLRT_CMD_LIMIT_SIX, 16'hffff);
		wr_reg(SLRT_CMD_LIMIT_FIVE, 16'ha5a5);
		wr_reg(SLRT_CMD_SLEW_FIVE, 16'hffff);
		wr_reg(8'hd4, 16'h1234);
		rd_reg(SLRT_CMD_LIMIT_SIX, 16'h00ff, 1'b1);
		rd_reg(SLRT_CMD_LIMIT_FIVE, 16'h00a5, 1'b1);
		rd_reg(SLRT_CMD_SLEW_FIVE, 16'h01ff, 1'b1);
		rd_reg(8'hd4, 16'h0000, 1'b0);
	endtask
	task automatic scn_fields();
		wr_reg(SLRT_CMD_SLEW_FIVE, 16'hfd55);
		rd_reg(SLRT_CMD_SLEW_FIVE, 16'h0155, 1'b1);
		chk({13'h0, cap}, 16'h0005);
		chk({10'h0, cur}, 16'h0015);
		@(posedge sys_clk_in);
		phases <= SLRT_PHASE_FIVE;
		#1;
		chk({15'h0, slew5}, 16'h0001);
	endtask
	task automatic scn_ramps();
		wr_reg(SLRT_CMD_LIMIT_SIX, 16'h0003);
		wr_reg(SLRT_CMD_LIMIT_FIVE, 16'h0008);
		ramp(SLRT_PHASE_SIX, 3);
		ramp(SLRT_PHASE_FIVE, 8);
		ramp(SLRT_PHASE_SIX, 3);
		wr_reg(SLRT_CMD_LIMIT_SIX, 16'h0000);
		ramp(SLRT_PHASE_SIX, 0);
		wr_reg(SLRT_CMD_LIMIT_FIVE, 16'h00ff);
		ramp(SLRT_PHASE_FIVE, 255);
	endtask
	// Phase counts without a limit keep the source on; elapsed time pins at full scale
	task automatic scn_unlimited();
		@(posedge sys_clk_in);
		phases <= 4'h4;
		start <= 1'b1;
		@(posedge sys_clk_in);
		start <= 1'b0;
		repeat (260) @(posedge sys_clk_in);
		#1;
		chk({15'h0, src_en}, 16'h0001);
		chk({15'h0, hold}, 16'h0000);
		chk({7'h0, elapsed}, 16'h01ff);
	endtask
	// Software side: limit and slew codes worked out from period and blanking
	task automatic scn_software();
		int switching_period_setting, blanking_setting, per_phase, lim6, lim5, mv, code;
		logic sense_gain_halve;
		switching_period_setting = 1200;
		blanking_setting = 50;
		sense_gain_halve = 1'b1;
		per_phase = switching_period_setting / 6 - blanking_setting;
		lim6 = (13 * per_phase) / (10 * SLRT_STEP_NS);
		per_phase = switching_period_setting / 5 - blanking_setting;
		lim5 = (13 * per_phase) / (10 * SLRT_STEP_NS);
		wr_reg(SLRT_CMD_LIMIT_SIX, 16'(lim6));
		wr_reg(SLRT_CMD_LIMIT_FIVE, 16'(lim5));
		ramp(SLRT_PHASE_SIX, 39);
		ramp(SLRT_PHASE_FIVE, 49);
		mv = 200;
		if (sense_gain_halve)
			mv = 2 * mv;
		code = (mv * (8 - 4) * 185) / (25 * per_phase);
		wr_reg(SLRT_CMD_SLEW_FIVE, 16'((4 << SLRT_CAP_LSB) | code));
		#1;
		chk({13'h0, cap}, 16'h0004);
		chk({10'h0, cur}, 16'h003e);
	endtask
	// Reset for three cycles, then the scenarios
	initial begin
		repeat (3) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		scn_regs();
		scn_fields();
		scn_ramps();
		scn_unlimited();
		scn_software();
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
